// ==== pwt_top.sv ====
// Eight channel pulse width timer with its Wishbone register slave.
// Assumes a classic Wishbone master on clk and pin direction bits
// supplied by the port block that owns the pins.
`timescale 1ns/1ps
`default_nettype none
module pwt_top #(
  parameter int NUM_CH = pwt_pkg::NUM_CH,
  parameter int ADDR_W = pwt_pkg::ADDR_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pin direction from the port block
  input wire logic [NUM_CH-1:0] pin_direction_bits,
  // Pulse outputs
  output logic [NUM_CH-1:0] pulse_outputs,
  output logic [NUM_CH-1:0] pulse_out_en
);

  // Bus request decode
  logic ack_q;
  logic ack_d;
  logic [31:0] dat_q;
  logic [31:0] dat_d;

  wire logic req = wb_cyc_i & wb_stb_i & ~ack_q;
  // Only lane 0 carries register data; a write without it stores nothing
  wire logic wr = req & wb_we_i & wb_sel_i[0];
  wire logic [7:0] wbyte = wb_dat_i[7:0];

  wire logic hit_select = wb_adr_i == ADDR_W'(pwt_pkg::OFF_SELECT);
  wire logic hit_duty = wb_adr_i == ADDR_W'(pwt_pkg::OFF_DUTY);
  wire logic hit_pol = wb_adr_i == ADDR_W'(pwt_pkg::OFF_POLARITY);
  wire logic hit_oe = wb_adr_i == ADDR_W'(pwt_pkg::OFF_OUT_EN);
  wire logic hit_pclk_raw = wb_adr_i == ADDR_W'(pwt_pkg::OFF_PCLK);
  wire logic hit_stc = wb_adr_i == ADDR_W'(pwt_pkg::OFF_STC);
  wire logic hit_count = wb_adr_i == ADDR_W'(pwt_pkg::OFF_COUNT);

  // Control registers
  logic clk_en_q;
  logic clk_en_d;
  logic clk_div_q;
  logic clk_div_d;
  logic [pwt_pkg::IDX_W-1:0] index_q;
  logic [pwt_pkg::IDX_W-1:0] index_d;
  logic [pwt_pkg::PSEL_W-1:0] psel_q;
  logic [pwt_pkg::PSEL_W-1:0] psel_d;
  logic flash_q;
  logic flash_d;
  logic [NUM_CH-1:0] pol_q;
  logic [NUM_CH-1:0] pol_d;
  logic [NUM_CH-1:0] oe_q;
  logic [NUM_CH-1:0] oe_d;
  logic [NUM_CH-1:0] drive_q;
  logic [NUM_CH-1:0] drive_d;
  logic [pwt_pkg::CNT_W-1:0] cnt_q;
  logic [pwt_pkg::CNT_W-1:0] cnt_d;
  logic [7:0] duty_q [NUM_CH];

  // Clock select register vanishes from the map while the flash bit is set
  wire logic hit_pclk = hit_pclk_raw & ~flash_q; // RULE5

  // Index with its top bit set points at no duty register
  wire logic idx_valid = ~index_q[pwt_pkg::IDX_W-1]; // RULE17
  wire logic [2:0] idx_ch = index_q[2:0]; // RULE16

  wire logic wr_select = wr & hit_select;
  wire logic wr_duty = wr & hit_duty & idx_valid; // RULE18
  wire logic wr_pol = wr & hit_pol;
  wire logic wr_oe = wr & hit_oe;
  wire logic wr_pclk = wr & hit_pclk;
  wire logic wr_stc = wr & hit_stc;

  // Select register: enable, divided select and index; bits 5 and 4 are fixed
  assign clk_en_d = wr_select ? wbyte[pwt_pkg::SEL_EN_BIT] : clk_en_q;
  assign clk_div_d = wr_select ? wbyte[pwt_pkg::SEL_DIV_BIT] : clk_div_q;
  assign index_d = wr_select
    ? wbyte[pwt_pkg::SEL_IDX_LSB +: pwt_pkg::IDX_W]
    : index_q;

  // Clock select register keeps only its three prescaler bits
  assign psel_d = wr_pclk
    ? wbyte[pwt_pkg::PCLK_SEL_LSB +: pwt_pkg::PSEL_W]
    : psel_q;

  assign flash_d = wr_stc ? wbyte[pwt_pkg::STC_FLASH_BIT] : flash_q;
  assign pol_d = wr_pol ? wbyte[NUM_CH-1:0] : pol_q;
  assign oe_d = wr_oe ? wbyte[NUM_CH-1:0] : oe_q;

  // Timer owns a pin only with both its enable and the direction bit set
  assign drive_d = oe_q & pin_direction_bits; // RULE22 RULE4

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      clk_en_q <= 1'b0; // RULE7
      clk_div_q <= 1'b0;
      index_q <= pwt_pkg::RST_IDX;
      psel_q <= pwt_pkg::RST_PSEL;
      flash_q <= 1'b0;
    end else begin
      clk_en_q <= clk_en_d;
      clk_div_q <= clk_div_d;
      index_q <= index_d;
      psel_q <= psel_d;
      flash_q <= flash_d;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pol_q <= '0;
      oe_q <= '0;
      drive_q <= '0;
    end else begin
      pol_q <= pol_d;
      oe_q <= oe_d;
      drive_q <= drive_d;
    end
  end

  // Clock selection
  pwt_pkg::pwt_clk_cfg_s clk_cfg;
  logic tick;

  assign clk_cfg.enable = clk_en_q; // RULE6
  assign clk_cfg.divided = clk_div_q;
  assign clk_cfg.psel = psel_q;

  pwt_prescaler u_prescaler (
    .clk(clk),
    .reset(reset),
    .cfg(clk_cfg),
    .tick(tick)
  );

  // Shared time base: one step per selected clock period, wrapping at 256
  // RULE1 RULE11 RULE12 RULE2
  assign cnt_d = tick ? cnt_q + 1'b1 : cnt_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Per channel duty registers and pulse generators
  logic [NUM_CH-1:0] pulse;
  logic [7:0] duty_rd [NUM_CH];

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      wire logic sel_me = wr_duty & (idx_ch == 3'(g)); // RULE16
      wire logic [7:0] duty_next = sel_me ? wbyte : duty_q[g];

      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          duty_q[g] <= pwt_pkg::RST_BYTE;
        end else begin
          duty_q[g] <= duty_next;
        end
      end

      pwt_channel u_channel (
        .clk(clk),
        .reset(reset),
        .count(cnt_q),
        .duty(duty_q[g]),
        .invert(pol_q[g]),
        .pulse(pulse[g])
      );

      assign duty_rd[g] = duty_q[g];
    end
  endgenerate

  // A disabled pin still shows the pulse level so the switch over is clean
  assign pulse_outputs = pulse;
  assign pulse_out_en = drive_q;

  // Read data
  wire logic [7:0] rd_select = {
    clk_en_q,
    clk_div_q,
    1'b1, // RULE14
    1'b0, // RULE15
    index_q
  };
  wire logic [7:0] rd_duty = idx_valid ? duty_rd[idx_ch] : 8'h00; // RULE18
  wire logic [7:0] rd_pclk = {4'h0, psel_q, 1'b0};
  wire logic [7:0] rd_stc = 8'(flash_q) << pwt_pkg::STC_FLASH_BIT;
  wire logic [7:0] rd_pol = 8'(pol_q);
  wire logic [7:0] rd_oe = 8'(oe_q);
  wire logic [7:0] rd_count = 8'(cnt_q);

  // Unmapped addresses and the hidden clock select register read zero
  wire logic [7:0] rd_byte =
    hit_select ? rd_select :
    hit_duty ? rd_duty :
    hit_pol ? rd_pol :
    hit_oe ? rd_oe :
    hit_pclk ? rd_pclk :
    hit_stc ? rd_stc :
    hit_count ? rd_count :
    8'h00;

  assign dat_d = req ? {24'h000000, rd_byte} : dat_q;
  // Ack one cycle after the strobe, dropped the cycle after
  assign ack_d = req;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else begin
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

endmodule : pwt_top
`default_nettype wire

// ==== pwt_pkg.sv ====
// Constants, field layout and carrier types of the eight channel pulse width timer.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
// Contract
// RULE1 - Eight pulse outputs share one time base and use pulse division.
// RULE2 - With undivided clock the carrier is the system clock over sixteen.
// RULE3 - Duty from 0 to 255/256 in 1/256 steps; full level is port output.
// RULE4 - Each output has its own polarity and its own timer enable.
// RULE5 - Clock select register is reachable only while the flash space bit is 0.
// RULE6 - Enable, divided select and three prescaler bits pick the counter clock.
// RULE7 - Clock enable 0, the reset value, stops the counter clock entirely.
// RULE8 - Enable 1, divided select 0: undivided clock, prescaler bits ignored.
// RULE9 - Divided select 1 with codes 000, 001, 010 divides by 2, 4, 8.
// RULE10 - Codes 011 to 111 divide by 16, 256, 512, 1024 and 4096.
// RULE11 - Resolution is one period of the selected counter clock.
// RULE12 - Conversion period is 256 counter clocks on an 8-bit wrapping counter.
// RULE13 - Each conversion period holds 16 basic pulses.
// RULE14 - Bit 5 of the select register reads 1 and ignores writes.
// RULE15 - Bit 4 of the select register reads 0 and ignores writes.
// RULE16 - Index codes 0000 to 0111 select channel duty registers 0 to 7.
// RULE17 - Index codes 1xxx select nothing and leave the timer untouched.
// RULE18 - Shared duty address reaches the duty register the index selects.
// RULE19 - Upper four duty bits set basic pulse high time in sixteenths.
// RULE20 - Lower four duty bits set how many basic pulses get one extra step.
// RULE21 - Polarity 0 sets high width, polarity 1 sets low width.
// RULE22 - Timer drives a pin only when its enable and direction bits are 1.
package pwt_pkg;
  localparam int CLK_HZ = 40000000;
  localparam int NUM_CH = 8;
  localparam int CNT_W = 8;
  localparam int PRE_W = 12;
  localparam int ADDR_W = 8;
  localparam int IDX_W = 4;
  localparam int PSEL_W = 3;
  // Register byte offsets
  localparam logic [7:0] OFF_SELECT = 8'h00;
  localparam logic [7:0] OFF_DUTY = 8'h04;
  localparam logic [7:0] OFF_POLARITY = 8'h08;
  localparam logic [7:0] OFF_OUT_EN = 8'h0c;
  localparam logic [7:0] OFF_PCLK = 8'h10;
  localparam logic [7:0] OFF_STC = 8'h14;
  localparam logic [7:0] OFF_COUNT = 8'h18;
  // Field positions
  localparam int SEL_EN_BIT = 7;
  localparam int SEL_DIV_BIT = 6;
  localparam int SEL_ONE_BIT = 5;
  localparam int SEL_ZERO_BIT = 4;
  localparam int SEL_IDX_LSB = 0;
  localparam int PCLK_SEL_LSB = 1;
  localparam int STC_FLASH_BIT = 3;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [PSEL_W-1:0] RST_PSEL = 3'h0;
  localparam logic [IDX_W-1:0] RST_IDX = 4'h0;

  typedef struct packed {
    logic enable;
    logic divided;
    logic [PSEL_W-1:0] psel;
  } pwt_clk_cfg_s;

  // Log2 of the divider for each prescaler code
  function automatic logic [3:0] pwt_div_log2(input logic [PSEL_W-1:0] code);
    case (code)
      3'h0: pwt_div_log2 = 4'h1;
      3'h1: pwt_div_log2 = 4'h2;
      3'h2: pwt_div_log2 = 4'h3;
      3'h3: pwt_div_log2 = 4'h4;
      3'h4: pwt_div_log2 = 4'h8;
      3'h5: pwt_div_log2 = 4'h9;
      3'h6: pwt_div_log2 = 4'ha;
      default: pwt_div_log2 = 4'hc;
    endcase
  endfunction : pwt_div_log2
endpackage : pwt_pkg

// ==== pwt_prescaler.sv ====
// Prescaler: turns the clock configuration into a one-cycle counter tick.
// Assumes the configuration is stable register state from the bus block.
`timescale 1ns/1ps
`default_nettype none
module pwt_prescaler (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Configuration
  input wire pwt_pkg::pwt_clk_cfg_s cfg,
  // Tick to the time base
  output logic tick
);
  logic [pwt_pkg::PRE_W-1:0] pre_q;
  logic [pwt_pkg::PRE_W-1:0] pre_d;
  wire logic [3:0] lg = pwt_pkg::pwt_div_log2(cfg.psel);
  wire logic [pwt_pkg::PRE_W:0] full = {{pwt_pkg::PRE_W{1'b0}}, 1'b1} << lg;
  wire logic [pwt_pkg::PRE_W:0] mask_wide = full - {{pwt_pkg::PRE_W{1'b0}}, 1'b1};
  wire logic [pwt_pkg::PRE_W-1:0] mask = mask_wide[pwt_pkg::PRE_W-1:0];
  wire logic div_hit = (pre_q & mask) == mask; // RULE9 RULE10

  // Held at zero while stopped so the first divided tick comes a full period late
  assign pre_d = cfg.enable ? pre_q + 1'b1 : '0;

  // RULE6 RULE7 RULE8
  assign tick = cfg.enable & (~cfg.divided | div_hit);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_d;
    end
  end
endmodule : pwt_prescaler
`default_nettype wire

// ==== pwt_channel.sv ====
// One pulse output: compares the shared count with its duty value.
// Assumes an 8-bit count stepped by the shared time base.
`timescale 1ns/1ps
`default_nettype none
module pwt_channel (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Shared time base and channel settings
  input wire logic [7:0] count,
  input wire logic [7:0] duty,
  input wire logic invert,
  // Pulse
  output logic pulse
);
  logic pulse_q;
  wire logic [3:0] slot = count[7:4]; // RULE13
  wire logic [3:0] pos = count[3:0];
  // Bit reversal spreads the extra steps evenly over the period
  wire logic [3:0] rev = {slot[0], slot[1], slot[2], slot[3]};
  wire logic extra = rev < duty[3:0]; // RULE20
  wire logic [4:0] limit = {1'b0, duty[7:4]} + {4'h0, extra}; // RULE19
  wire logic high = {1'b0, pos} < limit; // RULE3

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= high ^ invert; // RULE21
    end
  end

  assign pulse = pulse_q;
endmodule : pwt_channel
`default_nettype wire

// ==== pwt_monitor.sv ====
// Bus and pin checker for the pulse width timer top.
// Assumes it is bound to pwt_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module pwt_monitor #(
  parameter int NUM_CH = pwt_pkg::NUM_CH,
  parameter int ADDR_W = pwt_pkg::ADDR_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Pins
  input wire logic [NUM_CH-1:0] pin_direction_bits,
  input wire logic [NUM_CH-1:0] pulse_outputs,
  input wire logic [NUM_CH-1:0] pulse_out_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  wire req = wb_cyc_i && wb_stb_i;
  wire rd_ack = wb_ack_o && !wb_we_i;
  a_ack_follows_req: assert property (req && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_needs_req: assert property (!req |=> !wb_ack_o)
    else $error("ack without request");
  a_read_upper_zero: assert property (rd_ack |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_select_fixed_bits: assert property (
    rd_ack && wb_adr_i == pwt_pkg::OFF_SELECT |-> wb_dat_o[5:4] == 2'b10)
    else $error("select fixed bits wrong");
  a_pclk_reserved: assert property (
    rd_ack && wb_adr_i == pwt_pkg::OFF_PCLK |-> wb_dat_o[7:4] == 4'h0 && !wb_dat_o[0])
    else $error("clock select reserved bits set");
  a_unmapped_zero: assert property (rd_ack && wb_adr_i == 8'h1c |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_drive_needs_dir: assert property (
    (pulse_out_en & ~$past(pin_direction_bits)) == '0)
    else $error("pin driven while direction is input");
endmodule : pwt_monitor
bind pwt_top pwt_monitor #(.NUM_CH(NUM_CH), .ADDR_W(ADDR_W)) pwt_monitor_inst (
  .clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .pin_direction_bits(pin_direction_bits),
  .pulse_outputs(pulse_outputs), .pulse_out_en(pulse_out_en));
`default_nettype wire

// ==== pwt_load_model.sv ====
// Filter load model: integrates the high time seen on one chosen pin.
// Assumes pins already resolved, with a pull-down where undriven.
`timescale 1ns/1ps
`default_nettype none
module pwt_load_model (
  // Clock
  input wire logic clk,
  // Resolved pins
  input wire logic [7:0] pins,
  // Measurement control
  input wire logic [2:0] ch,
  input wire logic clr,
  // Integrated high time
  output logic [31:0] highs
);
  // Averaging high cycles is what the low pass filter does to the carrier
  always_ff @(posedge clk) begin
    if (clr) begin
      highs <= 32'h0;
    end else begin
      highs <= highs + {31'h0, pins[ch]};
    end
  end
endmodule : pwt_load_model
`default_nettype wire

// ==== tb_eight_channel_pwm_timer.sv ====
// Self-checking bench for the pulse width timer over classic Wishbone.
// Assumes pwt_pkg, pwt_top, the bound monitor and the load model.
`timescale 1ns/1ps
`default_nettype none
module tb_eight_channel_pwm_timer;
  logic clk = 0, reset = 1, cyc = 0, stb = 0, we = 0, clr = 0;
  logic [7:0] adr = 0, dir = 8'hff;
  logic [31:0] wdat = 0, rdat, highs;
  logic [3:0] sel = 4'h0, lanes = 4'h1;
  int divs [4] = '{256, 512, 1024, 4096};
  logic [2:0] ch = 0;
  wire [31:0] dat_o;
  wire ack;
  wire [7:0] pout, pen;
  wire [7:0] pins = pout & pen;
  logic [7:0] tbl [8] = '{8'h00, 8'h01, 8'h10, 8'h5a, 8'h80, 8'hf3, 8'hff, 8'h0f};
  int n_errors = 0, num_checks = 0;
  always #12.5 clk = ~clk;
  pwt_top pwt_top_inst (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .pin_direction_bits(dir), .pulse_outputs(pout), .pulse_out_en(pen));
  pwt_load_model pwt_load_model_inst (.clk(clk), .pins(pins), .ch(ch), .clr(clr),
    .highs(highs));
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; sel <= lanes; wdat <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 0; stb <= 0; we <= 0; sel <= 4'h0;
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(0, a, 8'h0);
    chk(rdat, exp);
  endtask : rd
  task automatic meas(input logic [2:0] c, input int period, input logic [31:0] exp);
    repeat (4) @(posedge clk);
    ch <= c; clr <= 1;
    @(posedge clk) clr <= 0;
    repeat (period) @(posedge clk);
    #1 chk(highs, exp);
  endtask : meas
  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(posedge clk);
    reset <= 0;
    rd(pwt_pkg::OFF_SELECT, 32'h20);
    rd(pwt_pkg::OFF_COUNT, 32'h0);
    repeat (20) @(posedge clk);
    rd(pwt_pkg::OFF_COUNT, 32'h0);
    bus(1, pwt_pkg::OFF_SELECT, 8'h37);
    rd(pwt_pkg::OFF_SELECT, 32'h27);
    for (int i = 0; i < 8; i++) begin
      bus(1, pwt_pkg::OFF_SELECT, 8'(i));
      bus(1, pwt_pkg::OFF_DUTY, tbl[i]);
    end
    for (int i = 0; i < 8; i++) begin
      bus(1, pwt_pkg::OFF_SELECT, 8'(i));
      rd(pwt_pkg::OFF_DUTY, {24'h0, tbl[i]});
    end
    bus(1, pwt_pkg::OFF_SELECT, 8'h08);
    bus(1, pwt_pkg::OFF_DUTY, 8'h77);
    rd(pwt_pkg::OFF_DUTY, 32'h0);
    bus(1, pwt_pkg::OFF_SELECT, 8'h00);
    rd(pwt_pkg::OFF_DUTY, {24'h0, tbl[0]});
    bus(1, pwt_pkg::OFF_STC, 8'h08);
    bus(1, pwt_pkg::OFF_PCLK, 8'h06);
    rd(pwt_pkg::OFF_PCLK, 32'h0);
    bus(1, pwt_pkg::OFF_STC, 8'h00);
    rd(pwt_pkg::OFF_PCLK, 32'h0);
    bus(1, pwt_pkg::OFF_PCLK, 8'hff);
    rd(pwt_pkg::OFF_PCLK, 32'h0e);
    rd(8'h1c, 32'h0);
    bus(1, pwt_pkg::OFF_OUT_EN, 8'hff);
    dir <= 8'h0f;
    repeat (3) @(posedge clk);
    chk({24'h0, pen}, 32'h0f);
    dir <= 8'hff;
    // Code 7 stays loaded: undivided mode must ignore it
    bus(1, pwt_pkg::OFF_SELECT, 8'h80);
    for (int i = 0; i < 8; i++) begin
      meas(3'(i), 256, {24'h0, tbl[i]});
    end
    bus(1, pwt_pkg::OFF_POLARITY, 8'hff);
    meas(3'd3, 256, 32'd256 - 32'h5a);
    bus(1, pwt_pkg::OFF_POLARITY, 8'h00);
    bus(1, pwt_pkg::OFF_SELECT, 8'hc0);
    for (int k = 0; k < 4; k++) begin
      bus(1, pwt_pkg::OFF_PCLK, 8'(k << 1));
      meas(3'd3, 256 << (k + 1), 32'h5a << (k + 1));
    end
    // Second reset in mid-run: select, polarity, duty 0 and pin enables must come back to their reset values
    @(posedge clk);
    reset <= 1;
    repeat (2) @(posedge clk);
    reset <= 0;
    rd(pwt_pkg::OFF_SELECT, 32'h20);
    rd(pwt_pkg::OFF_POLARITY, 32'h0);
    rd(pwt_pkg::OFF_DUTY, 32'h0);
    chk({24'h0, pen}, 32'h0);
    // A write without the low byte lane stores nothing
    lanes = 4'h2;
    bus(1, pwt_pkg::OFF_POLARITY, 8'hff);
    lanes = 4'h1;
    rd(pwt_pkg::OFF_POLARITY, 32'h0);
    // Slow dividers: the counter must step exactly once in one and a half periods
    for (int k = 0; k < 4; k++) begin
      bus(1, pwt_pkg::OFF_PCLK, 8'((k + 4) << 1));
      bus(1, pwt_pkg::OFF_SELECT, 8'hc0);
      repeat (divs[k] + divs[k] / 2 - 2) @(posedge clk);
      rd(pwt_pkg::OFF_COUNT, 32'(k + 1));
      bus(1, pwt_pkg::OFF_SELECT, 8'h40);
    end
    tally_and_finish();
  end
endmodule : tb_eight_channel_pwm_timer
`default_nettype wire
